// ---- hdl/sbc_cfg.svh ----
// Register offsets, field positions, reset values and command codes.
`ifndef SBC_CFG_SVH
`define SBC_CFG_SVH

`define SBC_ADDR_W          12
`define SBC_OFS_CTL         12'h000
`define SBC_OFS_STATUS      12'h004

`define SBC_CTL_TPC_LSB     0
`define SBC_CTL_RCD_LSB     2
`define SBC_CTL_TRWL_LSB    4
`define SBC_CTL_TRAS_LSB    6
`define SBC_CTL_BANKACT_BIT 9
`define SBC_CTL_SELFR_BIT   10
`define SBC_CTL_RFEN_BIT    11
`define SBC_CTL_CASLAT_LSB  12
`define SBC_CTL_BANK4_BIT   14
`define SBC_CTL_MASK        16'h7fff
`define SBC_CTL_RESET       16'h1000

`define SBC_STAT_OPEN_LSB   16
`define SBC_STAT_PEND_BIT   20
`define SBC_STAT_CKE_BIT    21

`define SBC_CMD_DESEL       4'hf
`define SBC_CMD_NOP         4'h7
`define SBC_CMD_ACT         4'h3
`define SBC_CMD_READ        4'h5
`define SBC_CMD_WRITE       4'h4
`define SBC_CMD_PRE         4'h2
`define SBC_CMD_REF         4'h1

`define SBC_AP_BIT          10

`endif

// ---- hdl/sbc_delay_timer.sv ----
// Down counter that times the wait states of the sequencer.
`timescale 1ns/10ps
module sbc_delay_timer (
    input  wire logic       sys_clk,  // System clock.
    input  wire logic       rst,      // Asynchronous reset, active high.
    input  wire logic       load,     // Load a new count.
    input  wire logic [3:0] loadVal,  // Cycles to wait minus one.
    output logic            expired   // Count has reached zero.
);

    logic [3:0] cnt_ff;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cnt_ff <= 4'h0;
        end else if (load) begin
            cnt_ff <= loadVal;
        end else if (cnt_ff != 4'h0) begin
            cnt_ff <= cnt_ff - 4'h1;
        end
    end

    assign expired = (cnt_ff == 4'h0);

endmodule : sbc_delay_timer

// ---- hdl/sbc_open_row_table.sv ----
// Open row record, one entry per internal memory bank.
`timescale 1ns/10ps
module sbc_open_row_table (
    input  wire logic        sys_clk,  // System clock.
    input  wire logic        rst,      // Asynchronous reset, active high.
    input  wire logic        setEn,    // Record row as open in bank.
    input  wire logic        clrEn,    // Mark bank closed.
    input  wire logic        clrAll,   // Mark every bank closed.
    input  wire logic [1:0]  bank,     // Addressed bank.
    input  wire logic [12:0] row,      // Addressed row.
    output logic             isOpen,   // Addressed bank has a row open.
    output logic             hit,      // Open row equals addressed row.
    output logic [3:0]       openMask  // Open flag of each bank.
);

    logic [12:0] rowFf [4];

    for (genvar b = 0; b < 4; b++) begin : g_bank
        always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
                openMask[b] <= 1'b0;
                rowFf[b]    <= 13'h0000;
            end else if (clrAll || (clrEn && bank == 2'(b))) begin
                openMask[b] <= 1'b0;
            end else if (setEn && bank == 2'(b)) begin
                openMask[b] <= 1'b1;
                rowFf[b]    <= row;
            end
        end
    end

    assign isOpen = openMask[bank];
    assign hit    = openMask[bank] && (rowFf[bank] == row);

endmodule : sbc_open_row_table

// ---- hdl/sbc_pkg.sv ----
// Types shared by the memory command sequencer.
package sbc_pkg;

    typedef enum logic [14:0] {
        ST_IDLE   = 15'h0001,
        ST_PRE    = 15'h0002,
        ST_PWAIT  = 15'h0004,
        ST_ACT    = 15'h0008,
        ST_RCDW   = 15'h0010,
        ST_NOP    = 15'h0020,
        ST_CMD    = 15'h0040,
        ST_RDW    = 15'h0080,
        ST_RECOV  = 15'h0100,
        ST_PCWAIT = 15'h0200,
        ST_RFPALL = 15'h0400,
        ST_RFPW   = 15'h0800,
        ST_RFREF  = 15'h1000,
        ST_RFWAIT = 15'h2000,
        ST_SELF   = 15'h4000
    } sbc_state_t;

    typedef enum logic [1:0] {
        PUR_AUTO = 2'h0,
        PUR_SELF = 2'h1,
        PUR_REL  = 2'h2
    } sbc_purpose_t;

    typedef struct packed {
        logic        write;
        logic [1:0]  bank;
        logic [12:0] row;
        logic [9:0]  col;
        logic [31:0] wdata;
        logic [3:0]  mask;
    } sbc_req_t;

    typedef struct packed {
        logic        cke;
        logic [3:0]  cmd;
        logic [12:0] addr;
        logic [1:0]  ba;
        logic [3:0]  dqm;
        logic [31:0] dqOut;
        logic        dqOeN;
    } sbc_pins_t;

endpackage : sbc_pkg

// ---- hdl/sbc_sdram_ctrl.sv ----
// Synchronous memory command sequencer with APB control registers.
//
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/10ps
`include "sbc_cfg.svh"

module sbc_sdram_ctrl
    import sbc_pkg::*;
(
    input  wire logic        sys_clk,     // System clock, 25 MHz.
    input  wire logic        rst,         // Asynchronous reset, active high.
    input  wire logic        psel,        // APB select.
    input  wire logic        penable,     // APB access phase.
    input  wire logic        pwrite,      // APB write.
    input  wire logic [11:0] paddr,       // APB byte address.
    input  wire logic [31:0] pwdata,      // APB write data.
    input  wire logic [3:0]  pstrb,       // APB byte strobes.
    output logic             pready,      // APB ready.
    output logic [31:0]      prdata,      // APB read data.
    output logic             pslverr,     // APB error, unmapped address.
    input  wire logic        reqValid,    // Memory access request.
    input  wire sbc_req_t    reqIn,       // Request fields.
    output logic             reqReady,    // Request taken this cycle.
    output logic             rspValid,    // Access finished, one pulse.
    output logic [31:0]      rspData,     // Read data.
    input  wire logic        refReq,      // Refresh request pulse.
    input  wire logic        busRelease,  // Bus handed to another master.
    output sbc_pins_t        pins,        // Memory pins.
    input  wire logic [31:0] dqIn         // Memory data bus input.
);

    sbc_state_t   state_ff;
    sbc_state_t   nxtState;
    sbc_purpose_t purpose_ff;
    sbc_purpose_t nxtPurpose;
    sbc_req_t     reqFf;
    sbc_req_t     curReq;
    sbc_pins_t    pins_ff;
    sbc_pins_t    nxtPins;
    logic [15:0]  ctl_ff;
    logic [31:0]  prdata_ff;
    logic         pendFf;
    logic         apFf;
    logic         curAp;
    logic         accept;
    logic         rspValid_ff;
    logic [31:0]  rspData_ff;
    logic         tLoad;
    logic [3:0]   tVal;
    logic         tDone;
    logic [1:0]   effBank;
    logic         rowOpen;
    logic         rowHit;
    logic [3:0]   openMask;
    logic         tblSet;
    logic         tblClr;
    logic         tblClrAll;
    logic [1:0]   fTpc;
    logic [1:0]   fRcd;
    logic [1:0]   fTrwl;
    logic [2:0]   fTras;
    logic [1:0]   fCas;
    logic         bankAct;
    logic         refresh_mode_bit;
    logic         rEn;
    logic         bank4;
    logic         selfWanted;
    logic         apbWr;

    assign fTpc    = ctl_ff[`SBC_CTL_TPC_LSB +: 2];
    assign fRcd    = ctl_ff[`SBC_CTL_RCD_LSB +: 2];
    assign fTrwl   = ctl_ff[`SBC_CTL_TRWL_LSB +: 2];
    assign fTras   = ctl_ff[`SBC_CTL_TRAS_LSB +: 3];
    assign fCas    = ctl_ff[`SBC_CTL_CASLAT_LSB +: 2];
    assign bankAct = ctl_ff[`SBC_CTL_BANKACT_BIT];
    assign refresh_mode_bit   = ctl_ff[`SBC_CTL_SELFR_BIT];
    assign rEn     = ctl_ff[`SBC_CTL_RFEN_BIT];
    assign bank4   = ctl_ff[`SBC_CTL_BANK4_BIT];

    assign selfWanted = refresh_mode_bit && rEn;

    // The register bus answers without wait states.
    assign pready  = 1'b1;
    assign pslverr = psel && penable && (paddr != `SBC_OFS_CTL)
                     && (paddr != `SBC_OFS_STATUS);
    assign prdata  = prdata_ff;
    assign apbWr   = psel && penable && pwrite && (paddr == `SBC_OFS_CTL);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ctl_ff <= `SBC_CTL_RESET;
        end else if (apbWr) begin
            if (pstrb[0]) begin
                ctl_ff[7:0] <= pwdata[7:0];
            end
            if (pstrb[1]) begin
                ctl_ff[15:8] <= pwdata[15:8] & 8'(`SBC_CTL_MASK >> 8);
            end
        end
    end

    // Read data is sampled in the setup phase and held for the access phase.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            prdata_ff <= 32'h0000_0000;
        end else if (psel && !penable) begin
            prdata_ff <= 32'h0000_0000;
            if (paddr == `SBC_OFS_CTL) begin
                prdata_ff <= {16'h0000, ctl_ff};
            end else if (paddr == `SBC_OFS_STATUS) begin
                prdata_ff[14:0] <= state_ff;
                prdata_ff[`SBC_STAT_OPEN_LSB +: 4] <= openMask;
                prdata_ff[`SBC_STAT_PEND_BIT] <= pendFf;
                prdata_ff[`SBC_STAT_CKE_BIT] <= pins_ff.cke;
            end
        end
    end

    // A new refresh request wins over the clear in the same cycle.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pendFf <= 1'b0;
        end else if (refReq) begin
            pendFf <= 1'b1;
        end else if (nxtState == ST_RFREF || state_ff == ST_SELF || !rEn) begin
            pendFf <= 1'b0;
        end
    end

    assign curReq  = (state_ff == ST_IDLE) ? reqIn : reqFf;
    assign curAp   = (state_ff == ST_IDLE) ? !bankAct : apFf;
    assign effBank = bank4 ? curReq.bank : {1'b0, curReq.bank[0]};

    // Open rows change only on this block's own commands, so cycles to
    // other address spaces never disturb them.
    assign tblSet    = (nxtState == ST_ACT) && !curAp;
    assign tblClr    = (nxtState == ST_PRE);
    assign tblClrAll = (nxtState == ST_RFPALL);

    sbc_open_row_table u_rows (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .setEn    (tblSet),
        .clrEn    (tblClr),
        .clrAll   (tblClrAll),
        .bank     (effBank),
        .row      (curReq.row),
        .isOpen   (rowOpen),
        .hit      (rowHit),
        .openMask (openMask)
    );

    sbc_delay_timer u_timer (
        .sys_clk (sys_clk),
        .rst     (rst),
        .load    (tLoad),
        .loadVal (tVal),
        .expired (tDone)
    );

    always_comb begin
        nxtState   = state_ff;
        nxtPurpose = purpose_ff;
        tLoad      = 1'b0;
        tVal       = 4'h0;
        accept     = 1'b0;
        case (state_ff)
            ST_IDLE: begin
                // Refresh is only started between bus cycles with the bus held.
                if (busRelease) begin
                    if (openMask != 4'h0) begin
                        nxtState   = ST_RFPALL;
                        nxtPurpose = PUR_REL;
                    end
                end else if (selfWanted) begin
                    nxtState   = ST_RFPALL;
                    nxtPurpose = PUR_SELF;
                end else if (pendFf && rEn) begin
                    nxtState   = ST_RFPALL;
                    nxtPurpose = PUR_AUTO;
                end else if (!bankAct && openMask != 4'h0) begin
                    nxtState   = ST_RFPALL;
                    nxtPurpose = PUR_REL;
                end else if (reqValid) begin
                    accept = 1'b1;
                    if (!bankAct || !rowOpen) begin
                        nxtState = ST_ACT;
                    end else if (rowHit) begin
                        if (!reqIn.write && fCas < 2'h2) begin
                            nxtState = ST_NOP;
                        end else begin
                            nxtState = ST_CMD;
                        end
                    end else begin
                        nxtState = ST_PRE;
                    end
                end
            end
            ST_PRE: begin
                nxtState = ST_PWAIT;
                tLoad    = 1'b1;
                tVal     = {2'h0, fTpc};
            end
            ST_PWAIT: begin
                if (tDone) begin
                    nxtState = ST_ACT;
                end
            end
            ST_ACT: begin
                if (fRcd == 2'h0) begin
                    nxtState = ST_CMD;
                end else begin
                    nxtState = ST_RCDW;
                    tLoad    = 1'b1;
                    tVal     = {2'h0, fRcd - 2'h1};
                end
            end
            ST_RCDW: begin
                if (tDone) begin
                    nxtState = ST_CMD;
                end
            end
            ST_NOP: begin
                nxtState = ST_CMD;
            end
            ST_CMD: begin
                if (!reqFf.write) begin
                    nxtState = ST_RDW;
                    tLoad    = 1'b1;
                    tVal     = {2'h0, (fCas == 2'h0) ? 2'h0 : fCas - 2'h1};
                end else if (apFf) begin
                    nxtState = ST_RECOV;
                    tLoad    = 1'b1;
                    tVal     = {2'h0, fTrwl};
                end else begin
                    nxtState = ST_IDLE;
                end
            end
            ST_RDW: begin
                if (tDone) begin
                    if (apFf) begin
                        nxtState = ST_PCWAIT;
                        tLoad    = 1'b1;
                        tVal     = {2'h0, fTpc};
                    end else begin
                        nxtState = ST_IDLE;
                    end
                end
            end
            ST_RECOV: begin
                if (tDone) begin
                    nxtState = ST_PCWAIT;
                    tLoad    = 1'b1;
                    tVal     = {2'h0, fTpc};
                end
            end
            ST_PCWAIT: begin
                if (tDone) begin
                    nxtState = ST_IDLE;
                end
            end
            ST_RFPALL: begin
                nxtState = ST_RFPW;
                tLoad    = 1'b1;
                tVal     = {2'h0, fTpc};
            end
            ST_RFPW: begin
                if (tDone) begin
                    case (purpose_ff)
                        PUR_AUTO: nxtState = ST_RFREF;
                        PUR_SELF: nxtState = ST_SELF;
                        default:  nxtState = ST_IDLE;
                    endcase
                end
            end
            ST_RFREF: begin
                nxtState = ST_RFWAIT;
                tLoad    = 1'b1;
                tVal     = {1'b0, fTras} + {2'h0, fTpc} + 4'h1;
            end
            ST_RFWAIT: begin
                if (tDone) begin
                    nxtState = ST_IDLE;
                end
            end
            ST_SELF: begin
                if (!selfWanted) begin
                    nxtState = ST_RFWAIT;
                    tLoad    = 1'b1;
                    tVal     = {2'h0, fTpc};
                end
            end
            default: begin
                nxtState = ST_IDLE;
            end
        endcase
    end

    assign reqReady = accept;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_ff   <= ST_IDLE;
            purpose_ff <= PUR_AUTO;
        end else begin
            state_ff   <= nxtState;
            purpose_ff <= nxtPurpose;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            reqFf <= '0;
            apFf  <= 1'b0;
        end else if (accept) begin
            reqFf <= reqIn;
            apFf  <= !bankAct;
        end
    end

    // Pin values are decoded from the coming state and registered.
    always_comb begin
        nxtPins       = '0;
        nxtPins.cke   = 1'b1;
        nxtPins.cmd   = `SBC_CMD_NOP;
        nxtPins.ba    = effBank;
        nxtPins.dqm   = 4'hf;
        nxtPins.dqOeN = 1'b1;
        case (nxtState)
            ST_ACT: begin
                nxtPins.dqm  = ~curReq.mask;
                nxtPins.cmd  = `SBC_CMD_ACT;
                nxtPins.addr = curReq.row;
            end
            ST_PRE: begin
                nxtPins.cmd = `SBC_CMD_PRE;
            end
            ST_RFPALL: begin
                nxtPins.cmd = `SBC_CMD_PRE;
                nxtPins.addr[`SBC_AP_BIT] = 1'b1;
            end
            ST_RCDW, ST_NOP: begin
                nxtPins.dqm = ~curReq.mask;
            end
            ST_CMD: begin
                nxtPins.cmd  = curReq.write ? `SBC_CMD_WRITE : `SBC_CMD_READ;
                nxtPins.addr = {2'h0, curAp, curReq.col};
                nxtPins.dqm  = ~curReq.mask;
                if (curReq.write) begin
                    nxtPins.dqOut = curReq.wdata;
                    nxtPins.dqOeN = 1'b0;
                end
            end
            ST_RFREF: begin
                nxtPins.cmd = `SBC_CMD_REF;
            end
            ST_SELF: begin
                nxtPins.cke = 1'b0;
                nxtPins.cmd = pins_ff.cke ? `SBC_CMD_REF : `SBC_CMD_DESEL;
            end
            default: begin
                nxtPins.cmd = `SBC_CMD_NOP;
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pins_ff       <= '0;
            pins_ff.cke   <= 1'b1;
            pins_ff.cmd   <= `SBC_CMD_DESEL;
            pins_ff.dqm   <= 4'hf;
            pins_ff.dqOeN <= 1'b1;
        end else begin
            pins_ff <= nxtPins;
        end
    end

    assign pins = pins_ff;

    // A write finishes when its command is on the pins; a read when its
    // data is sampled at the end of the latency wait.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rspValid_ff <= 1'b0;
            rspData_ff  <= 32'h0000_0000;
        end else begin
            rspValid_ff <= 1'b0;
            if (state_ff == ST_CMD && reqFf.write) begin
                rspValid_ff <= 1'b1;
            end else if (state_ff == ST_RDW && tDone) begin
                rspValid_ff <= 1'b1;
                rspData_ff  <= dqIn;
            end
        end
    end

    assign rspValid = rspValid_ff;
    assign rspData  = rspData_ff;

endmodule : sbc_sdram_ctrl

// ---- test/sbc_mem_model.sv ----
// Behavioural memory chip on the far side of the pins.
`timescale 1ns/10ps
`include "sbc_cfg.svh"
module sbc_mem_model
    import sbc_pkg::*;
(
    input  wire logic      sys_clk, // Clock.
    input  wire sbc_pins_t pins,    // Pins.
    output logic [31:0]    dqIn     // Read data.
);
    logic [31:0] mem [16];
    logic [31:0] rd_ff   = 32'h0;
    logic [2:0]  age_ff  = 3'h7;
    logic        tick_ff = 1'b0;
    always @(posedge sys_clk) begin
        tick_ff <= ~tick_ff;
        if (pins.cmd == `SBC_CMD_WRITE && !pins.dqOeN)
            mem[{pins.ba, pins.addr[1:0]}] <= pins.dqOut;
        if (pins.cmd == `SBC_CMD_READ) begin
            rd_ff <= mem[{pins.ba, pins.addr[1:0]}];
            age_ff <= 3'h0;
        end else if (age_ff != 3'h7) age_ff <= age_ff + 3'h1;
    end
    // Data is valid for three cycles after a read; otherwise it churns.
    assign dqIn = age_ff < 3'h3 ? rd_ff : ~rd_ff ^ {32{tick_ff}};
endmodule : sbc_mem_model

// ---- test/sbc_sdram_ctrl_asserts.sv ----
// Checker for the memory command sequencer.
`timescale 1ns/10ps
`include "sbc_cfg.svh"
module sbc_sdram_ctrl_asserts
    import sbc_pkg::*;
(
    input wire logic        sys_clk,    // Clock.
    input wire logic        rst,        // Reset.
    input wire logic        psel,       // Select.
    input wire logic        penable,    // Access.
    input wire logic        pwrite,     // Write.
    input wire logic [11:0] paddr,      // Address.
    input wire logic [31:0] pwdata,     // Data.
    input wire logic        reqReady,   // Taken.
    input wire logic        rspValid,   // Done.
    input wire logic        busRelease, // Released.
    input wire sbc_pins_t   pins        // Pins.
);
    logic [15:0] ctl_ff;
    logic [4:0]  sinceWr_ff;
    logic [4:0]  sincePre_ff;
    logic [4:0]  sinceRef_ff;
    wire logic [3:0] cmd  = pins.cmd;
    wire logic       busy = cmd != `SBC_CMD_NOP && cmd != `SBC_CMD_DESEL;
    wire logic [4:0] tpc  = 5'(ctl_ff[1:0]);
    wire logic [4:0] trw  = 5'(ctl_ff[5:4]);
    wire logic [4:0] tras = 5'(ctl_ff[8:6]);
    wire logic       ba   = ctl_ff[9];
    wire logic       wrAp = cmd == `SBC_CMD_WRITE && pins.addr[10];

    function automatic logic [4:0] step(logic hit, logic [4:0] n);
        return hit ? 5'h0 : (n == 5'h1f ? n : n + 5'h1);
    endfunction : step

    // Mirror of the control register, taken from completed APB writes.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) ctl_ff <= `SBC_CTL_RESET;
        else if (psel && penable && pwrite && paddr == `SBC_OFS_CTL)
            ctl_ff <= pwdata[15:0] & `SBC_CTL_MASK;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sinceWr_ff <= 5'h1f;
            sincePre_ff <= 5'h1f;
            sinceRef_ff <= 5'h1f;
        end else begin
            sinceWr_ff <= step(wrAp, sinceWr_ff);
            sincePre_ff <= step(cmd == `SBC_CMD_PRE, sincePre_ff);
            sinceRef_ff <= step(cmd == `SBC_CMD_REF, sinceRef_ff);
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    property p_wr_data;
        cmd == `SBC_CMD_WRITE |-> !pins.dqOeN ##1 rspValid;
    endproperty
    a_wr_data: assert property (p_wr_data)
        else $error("write command without data");
    property p_wr_ap;
        cmd == `SBC_CMD_WRITE && !ba |-> pins.addr[10];
    endproperty
    a_wr_ap: assert property (p_wr_ap)
        else $error("single write lacks auto-precharge");
    property p_ba_open;
        (cmd == `SBC_CMD_WRITE || cmd == `SBC_CMD_READ) && ba |-> !pins.addr[10];
    endproperty
    a_ba_open: assert property (p_ba_open)
        else $error("bank-active access used auto-precharge");
    property p_recov;
        busy |-> sinceWr_ff >= trw + tpc + 5'h2;
    endproperty
    a_recov: assert property (p_recov)
        else $error("command inside write recovery");
    property p_pre_act;
        cmd == `SBC_CMD_ACT |-> sincePre_ff >= tpc + 5'h1;
    endproperty
    a_pre_act: assert property (p_pre_act)
        else $error("activate too soon after precharge");
    property p_ref_wait;
        cmd == `SBC_CMD_REF |-> sincePre_ff == tpc + 5'h1;
    endproperty
    a_ref_wait: assert property (p_ref_wait)
        else $error("refresh not spaced from precharge");
    property p_ref_block;
        busy |-> sinceRef_ff >= tras + tpc + 5'h2;
    endproperty
    a_ref_block: assert property (p_ref_block)
        else $error("command inside refresh block");
    property p_nop_hit;
        cmd == `SBC_CMD_READ && ba && ctl_ff[13:12] < 2'h2
            |-> $past(pins.dqm) == pins.dqm;
    endproperty
    a_nop_hit: assert property (p_nop_hit)
        else $error("latency one read without idle cycle");
    property p_release;
        busRelease |-> !reqReady;
    endproperty
    a_release: assert property (p_release)
        else $error("request taken while bus released");
endmodule : sbc_sdram_ctrl_asserts

bind sbc_sdram_ctrl sbc_sdram_ctrl_asserts u_chk (.sys_clk(sys_clk),
    .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .reqReady(reqReady),
    .rspValid(rspValid), .busRelease(busRelease), .pins(pins));

// ---- test/test_sbc_sdram_ctrl.sv ----
// Self-checking bench for the memory command sequencer.
`timescale 1ns/10ps
`include "sbc_cfg.svh"
module test_sbc_sdram_ctrl
    import sbc_pkg::*;
;
    logic        sys_clk, rst, psel, penable, pwrite, pready, pslverr;
    logic        reqValid, reqReady, rspValid, refReq, busRelease, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rspData, dqIn, rd;
    sbc_req_t    reqIn;
    sbc_pins_t   pins;
    int          errors, comparisons;

    sbc_sdram_ctrl dut (.sys_clk(sys_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(4'hf), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .reqValid(reqValid), .reqIn(reqIn), .reqReady(reqReady),
        .rspValid(rspValid), .rspData(rspData), .refReq(refReq),
        .busRelease(busRelease), .pins(pins), .dqIn(dqIn));
    sbc_mem_model u_mem (.sys_clk(sys_clk), .pins(pins), .dqIn(dqIn));

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    task automatic report_and_stop();
        $display("Counts: %0d comparisons, %0d errors", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge sys_clk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 50) begin
            chk(32'h0, 32'h1);
            report_and_stop();
        end
    endtask : apb

    task automatic mem(input logic w, input logic [1:0] b,
                       input logic [12:0] r, input logic [9:0] c,
                       input logic [31:0] d);
        int n;
        @(posedge sys_clk);
        reqValid <= 1'b1;
        reqIn <= '{write: w, bank: b, row: r, col: c, wdata: d, mask: 4'hf};
        for (n = 0; n < 200; n++) begin
            @(posedge sys_clk);
            if (reqReady === 1'b1) break;
        end
        reqValid <= 1'b0;
        for (n = n; n < 400; n++) begin
            @(posedge sys_clk);
            if (rspValid === 1'b1) break;
        end
        rd = rspData;
        if (n == 400) begin
            chk(32'h0, 32'h1);
            report_and_stop();
        end
    endtask : mem

    task automatic waitStat(input logic [31:0] m, input logic [31:0] v);
        int n;
        for (n = 0; n < 100; n++) begin
            apb(1'b0, `SBC_OFS_STATUS, 32'h0);
            if ((rd & m) === v) break;
        end
        if (n == 100) begin
            chk(rd & m, v);
            report_and_stop();
        end
    endtask : waitStat
    initial begin
        {rst, psel, penable, pwrite, reqValid, refReq, busRelease} = 7'h40;
        {paddr, pwdata, reqIn} = '0;
        {errors, comparisons} = '0;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        apb(1'b0, `SBC_OFS_CTL, 32'h0);
        chk(rd, 32'h1000);
        apb(1'b0, 12'h0f0, 32'h0);
        chk({rd[30:0], err}, 32'h1);
        apb(1'b1, `SBC_OFS_STATUS, 32'hffff_ffff);
        waitStat(32'h7fff, 32'h1);
        $display("Register test done");
        apb(1'b1, `SBC_OFS_CTL, 32'h1015);
        mem(1'b1, 2'h0, 13'h5, 10'h1, 32'ha5a5_0001);
        mem(1'b0, 2'h0, 13'h5, 10'h1, 32'h0);
        chk(rd, 32'ha5a5_0001);
        $display("Single write test done");
        for (int lat = 1; lat < 4; lat++) begin
            apb(1'b1, `SBC_OFS_CTL, 32'h4215 | (lat << 12));
            mem(1'b1, 2'h1, 13'h7, 10'h2, 32'h1100 + lat);
            mem(1'b1, 2'h1, 13'h7, 10'h3, 32'h2200 + lat);
            mem(1'b0, 2'h1, 13'h7, 10'h2, 32'h0);
            chk(rd, 32'h1100 + lat);
            mem(1'b1, 2'h1, 13'h8, 10'h3, 32'h3300 + lat);
            mem(1'b0, 2'h1, 13'h8, 10'h3, 32'h0);
            chk(rd, 32'h3300 + lat);
            mem(1'b1, 2'h3, 13'h1, 10'h0, 32'h4400 + lat);
            waitStat(32'hf_0001, 32'ha_0001);
            apb(1'b1, `SBC_OFS_CTL, 32'h4015 | (lat << 12));
            waitStat(32'hf_0001, 32'h1);
        end
        $display("Bank active test done");
        apb(1'b1, `SBC_OFS_CTL, 32'h5a15);
        mem(1'b1, 2'h2, 13'h2, 10'h1, 32'h5555_aaaa);
        waitStat(32'hf_0001, 32'h4_0001);
        @(posedge sys_clk);
        refReq <= 1'b1;
        @(posedge sys_clk);
        refReq <= 1'b0;
        waitStat(32'h1f_0001, 32'h1);
        mem(1'b0, 2'h2, 13'h2, 10'h1, 32'h0);
        chk(rd, 32'h5555_aaaa);
        busRelease <= 1'b1;
        waitStat(32'h1f_0001, 32'h1);
        busRelease <= 1'b0;
        $display("Refresh and release test done");
        apb(1'b1, `SBC_OFS_CTL, 32'h5e15);
        waitStat(32'h20_0000, 32'h0);
        apb(1'b1, `SBC_OFS_CTL, 32'h5a15);
        waitStat(32'h3f_0001, 32'h20_0001);
        mem(1'b0, 2'h2, 13'h2, 10'h1, 32'h0);
        chk(rd, 32'h5555_aaaa);
        $display("Self refresh test done");
        report_and_stop();
    end
endmodule : test_sbc_sdram_ctrl
